// *** inc/status_defs.svh ***
// constants of the status and event register bank
//
// Function
// R1: questionable event register is 16 bits; only bits 0,1,9,11,12,13 are meaningful
// R2: questionable event query returns the register contents as a binary value
// R3: status preset clears the whole questionable enable mask
// R4: clear-status zeroes status byte, all event registers and empties the error queue
// R5: standard event mask is 8 bits; bits 0, 2 to 5 and 7 work
// R6: a mask write sets exactly the encoded bits and clears all others
// R7: standard event mask query returns the mask unchanged
// R8: standard event register query returns its current contents
// R9: operation-complete command sets bit 0 of the standard event register
// R10: operation-complete query answers with the value 1
// R11: power-on clear flag 1 zeroes both enable masks at power-up; 0 keeps them
// R12: power-on clear flag lives in non-volatile storage across power cycles
// R13: status byte mask is 8 bits; only bits 3 to 5 work
// R14: non-functional bits ignore writes and read back as zero
`ifndef STATUS_DEFS_SVH
`define STATUS_DEFS_SVH

// ============================================================
// functional bit masks
`define QUES_USED_MASK    16'h3A03
`define STD_EVT_USED_MASK 8'hBD
`define STB_USED_MASK     8'h38

// ============================================================
// field positions
`define STD_EVT_OPC_BIT   0
`define STB_QUES_BIT      3
`define STB_MAV_BIT       4
`define STB_ESB_BIT       5

// ============================================================
// reset values and fixed answers
`define MASK8_RESET       8'h00
`define MASK16_RESET      16'h0000
`define OPC_ANSWER        16'h0001

`endif

// *** inc/status_pkg.sv ***
// types shared by the status and event register bank
package status_pkg;

	typedef enum logic [3:0] {
		CMD_NONE       = 4'h0,
		CMD_QUES_WRITE = 4'h1,
		CMD_QUES_QUERY = 4'h2,
		CMD_PRESET     = 4'h3,
		CMD_CLEAR      = 4'h4,
		CMD_ESE_WRITE  = 4'h5,
		CMD_ESE_QUERY  = 4'h6,
		CMD_ESR_QUERY  = 4'h7,
		CMD_OPC        = 4'h8,
		CMD_OPC_QUERY  = 4'h9,
		CMD_PSC_WRITE  = 4'hA,
		CMD_PSC_QUERY  = 4'hB,
		CMD_SRE_WRITE  = 4'hC,
		CMD_SRE_QUERY  = 4'hD,
		CMD_STB_QUERY  = 4'hE
	} cmd_e;

	typedef enum logic [1:0] {
		ST_RESET = 2'b00,
		ST_LOAD  = 2'b01,
		ST_RUN   = 2'b11
	} init_state_e;

endpackage : status_pkg

// *** inc/status_cmd_if.sv ***
// decoded command strobes between decoder and register bank
`timescale 1ns/1ps
`default_nettype none

interface status_cmd_if;
	logic ques_write;
	logic ques_query;
	logic preset;
	logic clear;
	logic ese_write;
	logic ese_query;
	logic esr_query;
	logic opc;
	logic opc_query;
	logic psc_write;
	logic psc_query;
	logic sre_write;
	logic sre_query;
	logic stb_query;
	logic unknown;

	modport decoder (
		output ques_write, ques_query, preset, clear, ese_write, ese_query,
		       esr_query, opc, opc_query, psc_write, psc_query, sre_write,
		       sre_query, stb_query, unknown
	);
	modport bank (
		input  ques_write, ques_query, preset, clear, ese_write, ese_query,
		       esr_query, opc, opc_query, psc_write, psc_query, sre_write,
		       sre_query, stb_query, unknown
	);
endinterface : status_cmd_if

`default_nettype wire

// *** core/status_cmd_decode.sv ***
// decodes a command code into one-hot strobes
`timescale 1ns/1ps
`default_nettype none

module status_cmd_decode
	import status_pkg::*;
(
	// command in
	input  wire logic       i_valid,
	input  wire logic [3:0] i_code,
	input  wire logic       i_ready,
	// strobes out
	status_cmd_if.decoder   cmd
);
	cmd_e code;
	logic go;

	assign code = cmd_e'(i_code);
	// commands are ignored until the bank has finished its power-up load
	assign go = i_valid & i_ready;

	always_comb begin
		cmd.ques_write = 1'b0;
		cmd.ques_query = 1'b0;
		cmd.preset     = 1'b0;
		cmd.clear      = 1'b0;
		cmd.ese_write  = 1'b0;
		cmd.ese_query  = 1'b0;
		cmd.esr_query  = 1'b0;
		cmd.opc        = 1'b0;
		cmd.opc_query  = 1'b0;
		cmd.psc_write  = 1'b0;
		cmd.psc_query  = 1'b0;
		cmd.sre_write  = 1'b0;
		cmd.sre_query  = 1'b0;
		cmd.stb_query  = 1'b0;
		cmd.unknown    = 1'b0;
		if (go) begin
			unique case (code)
				CMD_QUES_WRITE: cmd.ques_write = 1'b1;
				CMD_QUES_QUERY: cmd.ques_query = 1'b1;
				CMD_PRESET:     cmd.preset     = 1'b1;
				CMD_CLEAR:      cmd.clear      = 1'b1;
				CMD_ESE_WRITE:  cmd.ese_write  = 1'b1;
				CMD_ESE_QUERY:  cmd.ese_query  = 1'b1;
				CMD_ESR_QUERY:  cmd.esr_query  = 1'b1;
				CMD_OPC:        cmd.opc        = 1'b1;
				CMD_OPC_QUERY:  cmd.opc_query  = 1'b1;
				CMD_PSC_WRITE:  cmd.psc_write  = 1'b1;
				CMD_PSC_QUERY:  cmd.psc_query  = 1'b1;
				CMD_SRE_WRITE:  cmd.sre_write  = 1'b1;
				CMD_SRE_QUERY:  cmd.sre_query  = 1'b1;
				CMD_STB_QUERY:  cmd.stb_query  = 1'b1;
				default:        cmd.unknown    = 1'b1;
			endcase
		end
	end
endmodule : status_cmd_decode

`default_nettype wire

// *** core/status_event_register_bank.sv ***
// status byte, standard event and questionable event register bank
`timescale 1ns/1ps
`default_nettype none
`include "status_defs.svh"

module status_event_register_bank
	import status_pkg::*;
#(
	parameter int QUES_WIDTH = 16,
	parameter int BYTE_WIDTH = 8
)(
	// clock and power-up reset
	input  wire logic                  i_clock,
	input  wire logic                  i_arst_n,
	// command port from the parser
	input  wire logic                  i_cmd_valid,
	input  wire logic [3:0]            i_cmd_code,
	input  wire logic [QUES_WIDTH-1:0] i_cmd_data,
	output logic                       o_cmd_ready,
	// query answers to the output buffer
	output logic                       o_resp_valid,
	output logic [QUES_WIDTH-1:0]      o_resp_data,
	output logic                       o_cmd_unknown,
	// event sources from the instrument
	input  wire logic [QUES_WIDTH-1:0] i_ques_event,
	input  wire logic [BYTE_WIDTH-1:0] i_std_event,
	input  wire logic                  i_out_avail,
	// non-volatile storage
	input  wire logic                  i_nv_psc,
	input  wire logic [BYTE_WIDTH-1:0] i_nv_sre,
	input  wire logic [BYTE_WIDTH-1:0] i_nv_ese,
	output logic                       o_nv_psc_write,
	output logic                       o_nv_psc_data,
	// state out
	output logic [BYTE_WIDTH-1:0]      o_status_byte,
	output logic [BYTE_WIDTH-1:0]      o_sre_mask,
	output logic [BYTE_WIDTH-1:0]      o_ese_mask,
	output logic [QUES_WIDTH-1:0]      o_ques_enable,
	output logic                       o_err_queue_clear
);
	localparam logic [QUES_WIDTH-1:0] QUES_USED = QUES_WIDTH'(`QUES_USED_MASK);
	localparam logic [BYTE_WIDTH-1:0] STD_USED  = BYTE_WIDTH'(`STD_EVT_USED_MASK);
	localparam logic [BYTE_WIDTH-1:0] STB_USED  = BYTE_WIDTH'(`STB_USED_MASK);

	// ============================================================
	// command decode
	status_cmd_if cmd ();

	status_cmd_decode u_decode (
		.i_valid (i_cmd_valid),
		.i_code  (i_cmd_code),
		.i_ready (o_cmd_ready),
		.cmd     (cmd)
	);

	// ============================================================
	// power-up sequencing
	init_state_e state_reg;
	init_state_e state_next;
	logic        psc_reg;
	logic        psc_next;

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_RESET: state_next = ST_LOAD;
			ST_LOAD:  state_next = ST_RUN;
			ST_RUN:   state_next = ST_RUN;
			default:  state_next = ST_RESET;
		endcase
	end

	assign o_cmd_ready = (state_reg == ST_RUN);

	// ============================================================
	// register state
	logic [QUES_WIDTH-1:0] ques_bits_reg;
	logic [QUES_WIDTH-1:0] ques_bits_next;
	logic [QUES_WIDTH-1:0] ques_en_reg;
	logic [QUES_WIDTH-1:0] ques_en_next;
	logic [BYTE_WIDTH-1:0] std_bits_reg;
	logic [BYTE_WIDTH-1:0] std_bits_next;
	logic [BYTE_WIDTH-1:0] ese_reg;
	logic [BYTE_WIDTH-1:0] ese_next;
	logic [BYTE_WIDTH-1:0] sre_reg;
	logic [BYTE_WIDTH-1:0] sre_next;
	logic [BYTE_WIDTH-1:0] stb_reg;
	logic [BYTE_WIDTH-1:0] stb_next;
	logic                  nv_wr_reg;
	logic                  nv_wr_next;
	logic                  err_clr_reg;
	logic                  err_clr_next;
	logic [BYTE_WIDTH-1:0] stb_live;

	always_comb begin
		ques_bits_next = ques_bits_reg;
		ques_en_next   = ques_en_reg;
		std_bits_next  = std_bits_reg;
		ese_next       = ese_reg;
		sre_next       = sre_reg;
		psc_next       = psc_reg;
		nv_wr_next     = 1'b0;
		err_clr_next   = 1'b0;

		if (state_reg == ST_LOAD) begin
			// the stored flag decides whether saved masks come back
			psc_next = i_nv_psc;                                  // R12
			if (i_nv_psc) begin
				ese_next = `MASK8_RESET;                          // R11
				sre_next = `MASK8_RESET;                          // R11
			end else begin
				ese_next = i_nv_ese & STD_USED;                   // R11 R14
				sre_next = i_nv_sre & STB_USED;                   // R11 R14
			end
		end

		if (cmd.clear) begin
			ques_bits_next = `MASK16_RESET;                       // R4
			std_bits_next  = `MASK8_RESET;                        // R4
			err_clr_next   = 1'b1;                                // R4
		end
		if (cmd.ques_write) begin
			ques_bits_next = i_cmd_data & QUES_USED;              // R1 R14
		end
		if (cmd.preset) begin
			ques_en_next = `MASK16_RESET;                         // R3
		end
		if (cmd.ese_write) begin
			ese_next = i_cmd_data[BYTE_WIDTH-1:0] & STD_USED;     // R5 R6 R14
		end
		if (cmd.sre_write) begin
			sre_next = i_cmd_data[BYTE_WIDTH-1:0] & STB_USED;     // R13 R6 R14
		end
		if (cmd.psc_write) begin
			psc_next   = i_cmd_data[0];                           // R12
			nv_wr_next = 1'b1;                                    // R12
		end
		if (cmd.opc) begin
			std_bits_next[`STD_EVT_OPC_BIT] = 1'b1;               // R9
		end

		// new events are applied last, so an event in a clear cycle survives
		if (state_reg == ST_RUN) begin
			ques_bits_next = ques_bits_next | (i_ques_event & QUES_USED);  // R1 R14
			std_bits_next  = std_bits_next | (i_std_event & STD_USED);     // R14
		end
	end

	// ============================================================
	// status byte summary
	always_comb begin
		stb_live = '0;
		stb_live[`STB_QUES_BIT] = |(ques_bits_next & ques_en_next);
		stb_live[`STB_MAV_BIT]  = i_out_avail & ~cmd.clear;        // R4
		stb_live[`STB_ESB_BIT]  = |(std_bits_next & ese_next);
		stb_next = stb_live & STB_USED;                            // R14
	end

	// ============================================================
	// query answers
	logic                  resp_valid_reg;
	logic                  resp_valid_next;
	logic [QUES_WIDTH-1:0] resp_data_reg;
	logic [QUES_WIDTH-1:0] resp_data_next;
	logic                  unknown_reg;

	always_comb begin
		resp_valid_next = 1'b1;
		resp_data_next  = resp_data_reg;
		if (cmd.ques_query) begin
			resp_data_next = ques_bits_reg;                             // R2
		end else if (cmd.ese_query) begin
			resp_data_next = QUES_WIDTH'(ese_reg);                      // R7
		end else if (cmd.esr_query) begin
			resp_data_next = QUES_WIDTH'(std_bits_reg);                 // R8
		end else if (cmd.opc_query) begin
			resp_data_next = `OPC_ANSWER;                               // R10
		end else if (cmd.psc_query) begin
			resp_data_next = QUES_WIDTH'(psc_reg);
		end else if (cmd.sre_query) begin
			resp_data_next = QUES_WIDTH'(sre_reg);
		end else if (cmd.stb_query) begin
			resp_data_next = QUES_WIDTH'(stb_reg);
		end else begin
			resp_valid_next = 1'b0;
		end
	end

	// ============================================================
	// registers
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_reg      <= ST_RESET;
			psc_reg        <= 1'b0;
			ques_bits_reg  <= `MASK16_RESET;
			ques_en_reg    <= `MASK16_RESET;
			std_bits_reg   <= `MASK8_RESET;
			ese_reg        <= `MASK8_RESET;
			sre_reg        <= `MASK8_RESET;
			stb_reg        <= `MASK8_RESET;
			nv_wr_reg      <= 1'b0;
			err_clr_reg    <= 1'b0;
			resp_valid_reg <= 1'b0;
			resp_data_reg  <= `MASK16_RESET;
			unknown_reg    <= 1'b0;
		end else begin
			state_reg      <= state_next;
			psc_reg        <= psc_next;
			ques_bits_reg  <= ques_bits_next;
			ques_en_reg    <= ques_en_next;
			std_bits_reg   <= std_bits_next;
			ese_reg        <= ese_next;
			sre_reg        <= sre_next;
			stb_reg        <= stb_next;
			nv_wr_reg      <= nv_wr_next;
			err_clr_reg    <= err_clr_next;
			resp_valid_reg <= resp_valid_next;
			resp_data_reg  <= resp_data_next;
			unknown_reg    <= cmd.unknown;
		end
	end

	// ============================================================
	// outputs
	assign o_resp_valid      = resp_valid_reg;
	assign o_resp_data       = resp_data_reg;
	assign o_cmd_unknown     = unknown_reg;
	assign o_nv_psc_write    = nv_wr_reg;
	assign o_nv_psc_data     = psc_reg;
	assign o_status_byte     = stb_reg;
	assign o_sre_mask        = sre_reg;
	assign o_ese_mask        = ese_reg;
	assign o_ques_enable     = ques_en_reg;
	assign o_err_queue_clear = err_clr_reg;

endmodule : status_event_register_bank

`default_nettype wire

// *** sim/status_event_register_bank_chk.sv ***
// port assertions of the status and event register bank
`timescale 1ns/1ps
`default_nettype none

module status_event_register_bank_chk
	import status_pkg::*;
(
	input  wire logic        i_clock,
	input  wire logic        i_arst_n,
	input  wire logic        i_cmd_valid,
	input  wire logic [3:0]  i_cmd_code,
	input  wire logic [15:0] i_cmd_data,
	input  wire logic        o_cmd_ready,
	input  wire logic        o_resp_valid,
	input  wire logic [15:0] o_resp_data,
	input  wire logic        i_nv_psc,
	input  wire logic [7:0]  i_nv_ese,
	input  wire logic        o_nv_psc_write,
	input  wire logic        o_nv_psc_data,
	input  wire logic [7:0]  o_sre_mask,
	input  wire logic [7:0]  o_ese_mask,
	input  wire logic [15:0] o_ques_enable,
	input  wire logic        o_err_queue_clear
);
	// ==========
	// command taken at this edge
	logic take;
	assign take = i_cmd_valid && o_cmd_ready;
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_arst_n);

	a_query_answered: assert property (
		take && i_cmd_code inside {CMD_QUES_QUERY, CMD_ESE_QUERY, CMD_ESR_QUERY} |=> o_resp_valid)
		else $error("query without answer");
	a_mask_write: assert property (
		take && i_cmd_code == CMD_ESE_WRITE |=> o_ese_mask == ($past(i_cmd_data[7:0]) & 8'hBD))
		else $error("mask write wrong");
	a_mask_query: assert property (
		take && i_cmd_code == CMD_ESE_QUERY |=> o_resp_data == {8'h00, $past(o_ese_mask)}
			&& $stable(o_ese_mask))
		else $error("mask query wrong");
	a_unused_zero: assert property (
		(o_ese_mask & 8'h42) == 8'h00 && (o_sre_mask & 8'hC7) == 8'h00)
		else $error("unused mask bit set");
	a_opc_one: assert property (
		take && i_cmd_code == CMD_OPC_QUERY |=> o_resp_valid && o_resp_data == 16'h0001)
		else $error("completion query not one");
	a_preset_clears: assert property (
		take && i_cmd_code == CMD_PRESET |=> o_ques_enable == 16'h0000)
		else $error("preset left enable bits");
	a_clear_queue: assert property (
		take && i_cmd_code == CMD_CLEAR |=> o_err_queue_clear)
		else $error("error queue not cleared");
	a_flag_stored: assert property (
		take && i_cmd_code == CMD_PSC_WRITE |=> o_nv_psc_write
			&& o_nv_psc_data == $past(i_cmd_data[0]))
		else $error("flag not stored");
	a_powerup_masks: assert property (
		$rose(o_cmd_ready) |-> o_ese_mask == ($past(i_nv_psc) ? 8'h00 : $past(i_nv_ese) & 8'hBD))
		else $error("power-up mask wrong");
endmodule : status_event_register_bank_chk

bind status_event_register_bank status_event_register_bank_chk chk_inst (
	.i_clock(i_clock), .i_arst_n(i_arst_n), .i_cmd_valid(i_cmd_valid),
	.i_cmd_code(i_cmd_code), .i_cmd_data(i_cmd_data), .o_cmd_ready(o_cmd_ready),
	.o_resp_valid(o_resp_valid), .o_resp_data(o_resp_data), .i_nv_psc(i_nv_psc),
	.i_nv_ese(i_nv_ese), .o_nv_psc_write(o_nv_psc_write), .o_nv_psc_data(o_nv_psc_data),
	.o_sre_mask(o_sre_mask), .o_ese_mask(o_ese_mask), .o_ques_enable(o_ques_enable),
	.o_err_queue_clear(o_err_queue_clear)
);

`default_nettype wire

// *** sim/status_host_model.sv ***
// host controller and non-volatile flag storage on the command port
`timescale 1ns/1ps
`default_nettype none

module status_host_model
	import status_pkg::*;
(
	input  wire logic        i_clock,
	output logic             o_cmd_valid,
	output logic [3:0]       o_cmd_code,
	output logic [15:0]      o_cmd_data,
	input  wire logic        i_resp_valid,
	input  wire logic [15:0] i_resp_data,
	input  wire logic        i_nv_write,
	input  wire logic        i_nv_data,
	output logic             o_nv_psc
);
	// ==========
	// storage is never reset, so the flag outlives a power cycle of the bank
	initial begin
		o_cmd_valid = 1'b0;
		o_cmd_code  = 4'h0;
		o_cmd_data  = 16'h0000;
		o_nv_psc    = 1'b0;
	end
	always @(posedge i_clock) begin
		if (i_nv_write)
			o_nv_psc <= i_nv_data;
	end

	// ==========
	// one command; answer read just after the taking edge has landed
	task automatic send(input cmd_e code, input logic [15:0] data, output logic [16:0] resp);
		@(posedge i_clock);
		o_cmd_valid <= 1'b1;
		o_cmd_code  <= code;
		o_cmd_data  <= data;
		@(posedge i_clock);
		o_cmd_valid <= 1'b0;
		// released lines never keep the stale value
		o_cmd_code  <= ~code;
		o_cmd_data  <= ~data;
		#1;
		resp = {i_resp_valid, i_resp_data};
	endtask : send
endmodule : status_host_model

`default_nettype wire

// *** sim/tb_status_event_register_bank.sv ***
// testbench of the status and event register bank
`timescale 1ns/1ps
`default_nettype none

module tb_status_event_register_bank
	import status_pkg::*;
;
	logic        clock = 1'b0;
	logic        arst_n = 1'b0;
	logic        valid, nv_psc, rvalid, ready, unknown, nv_wr, nv_data, eq_clr;
	logic [3:0]  code;
	logic [15:0] data, rdata, ques_en;
	logic [15:0] ques_ev = 16'h0000;
	logic [7:0]  std_ev = 8'h00;
	logic        avail = 1'b0;
	logic [7:0]  stb, sre, standard_event_mask;
	logic [16:0] r;
	int          err_total = 0;
	int          total_checks = 0;

	always #12.5 clock = ~clock;

	status_event_register_bank status_event_register_bank_inst (
		.i_clock(clock), .i_arst_n(arst_n), .i_cmd_valid(valid), .i_cmd_code(code),
		.i_cmd_data(data), .o_cmd_ready(ready), .o_resp_valid(rvalid), .o_resp_data(rdata),
		.o_cmd_unknown(unknown), .i_ques_event(ques_ev), .i_std_event(std_ev),
		.i_out_avail(avail), .i_nv_psc(nv_psc), .i_nv_sre(8'hFF), .i_nv_ese(8'hFF),
		.o_nv_psc_write(nv_wr), .o_nv_psc_data(nv_data), .o_status_byte(stb),
		.o_sre_mask(sre), .o_ese_mask(standard_event_mask), .o_ques_enable(ques_en), .o_err_queue_clear(eq_clr)
	);
	status_host_model status_host_model_inst (
		.i_clock(clock), .o_cmd_valid(valid), .o_cmd_code(code), .o_cmd_data(data),
		.i_resp_valid(rvalid), .i_resp_data(rdata), .i_nv_write(nv_wr), .i_nv_data(nv_data),
		.o_nv_psc(nv_psc)
	);

	// ==========
	// helpers
	task automatic check(input logic [16:0] got, input logic [16:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic print_verdict();
		$display("mismatches %0d, checks %0d", err_total, total_checks);
		if (err_total == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : print_verdict
	task automatic w(input cmd_e c, input logic [15:0] d);
		status_host_model_inst.send(c, d, r);
	endtask : w
	task automatic q(input cmd_e c, input logic [15:0] exp);
		status_host_model_inst.send(c, 16'h0000, r);
		check(r, {1'b1, exp});
	endtask : q
	// ready is due two edges after release, so a fixed wait is safe
	task automatic power();
		@(posedge clock);
		arst_n <= 1'b0;
		repeat (12) @(posedge clock);
		arst_n <= 1'b1;
		repeat (3) @(posedge clock);
		#1;
		check({16'h0000, ready}, 17'h00001);
	endtask : power
	// event inputs stand for exactly one sampling edge
	task automatic pulse(input logic [15:0] qv, input logic [7:0] sv);
		@(posedge clock);
		ques_ev <= qv;
		std_ev  <= sv;
		@(posedge clock);
		ques_ev <= 16'h0000;
		std_ev  <= 8'h00;
	endtask : pulse

	// ==========
	// tests
	initial begin
		power();
		check({1'b0, sre, standard_event_mask}, {1'b0, 8'h38, 8'hBD});
		w(CMD_ESE_WRITE, 16'h00A0);
		q(CMD_ESE_QUERY, 16'h00A0);
		q(CMD_ESE_QUERY, 16'h00A0);
		w(CMD_ESE_WRITE, 16'hFFFF);
		q(CMD_ESE_QUERY, 16'h00BD);
		w(CMD_SRE_WRITE, 16'h00FF);
		q(CMD_SRE_QUERY, 16'h0038);
		w(CMD_QUES_WRITE, 16'hFFFF);
		q(CMD_QUES_QUERY, 16'h3A03);
		w(CMD_OPC, 16'h0000);
		q(CMD_ESR_QUERY, 16'h0001);
		q(CMD_OPC_QUERY, 16'h0001);
		pulse(16'h0000, 8'h42);
		q(CMD_ESR_QUERY, 16'h0001);
		pulse(16'h0000, 8'h80);
		q(CMD_ESR_QUERY, 16'h0081);
		// summary byte sees output data and the enabled standard events
		@(posedge clock);
		avail <= 1'b1;
		@(posedge clock);
		#1;
		check({9'h000, stb}, 17'h00030);
		w(CMD_CLEAR, 16'h0000);
		check({16'h0000, eq_clr}, 17'h00001);
		check({9'h000, stb}, 17'h00000);
		// clear only masks the data-available bit for its own update
		@(posedge clock);
		avail <= 1'b0;
		#1;
		check({9'h000, stb}, 17'h00010);
		q(CMD_ESR_QUERY, 16'h0000);
		q(CMD_QUES_QUERY, 16'h0000);
		q(CMD_STB_QUERY, 16'h0000);
		pulse(16'hFFFF, 8'h00);
		q(CMD_QUES_QUERY, 16'h3A03);
		w(CMD_PRESET, 16'h0000);
		check({1'b0, ques_en}, 17'h00000);
		w(CMD_NONE, 16'h0000);
		check({16'h0000, unknown}, 17'h00001);
		w(CMD_PSC_WRITE, 16'h0001);
		q(CMD_PSC_QUERY, 16'h0001);
		power();
		check({1'b0, sre, standard_event_mask}, 17'h00000);
		q(CMD_PSC_QUERY, 16'h0001);
		print_verdict();
	end

	initial begin
		repeat (4000) @(posedge clock);
		err_total++;
		print_verdict();
	end
endmodule : tb_status_event_register_bank

`default_nettype wire
